// >>> hdl/ppsl_params.svh
// Constants for the port power and strap latch block
// What this block does
// - Drive port power enable 1 on, 0 off
// - Combined pin: open-drain enable plus over-current input
// - Latch charge-support strap; 1 enables, 0 disables
// - Sample local-power input during post-reset configuration
// - Hold latched local-power value until next reset
// - Mode value 0x41 at 0x4134 tracks input dynamically
// - Mode register written over SMBus or from OTP
// - Local-power detect in use: non-removable from register
// - Straps captured at power-on and external reset release
`ifndef PPSL_PARAMS_SVH
`define PPSL_PARAMS_SVH

`define PPSL_MODE_ADDR      16'h4134
`define PPSL_MODE_RESET     8'hC1
`define PPSL_MODE_DYNAMIC   8'h41
`define PPSL_PCFG_ADDR      16'h4135
`define PPSL_PCFG_RESET     8'h00
`define PPSL_PCFG_NONREM_LSB 0
`define PPSL_PCFG_COMB_LSB  2
`define PPSL_PCFG_LPD_BIT   4
`define PPSL_CLK_PERIOD_NS  20
`define PPSL_CFG_TIME_NS    1000
`define PPSL_CFG_CYCLES \
	((`PPSL_CFG_TIME_NS + `PPSL_CLK_PERIOD_NS - 1) / `PPSL_CLK_PERIOD_NS)

`endif

// >>> hdl/ppsl_pkg.sv
// Types shared by the port power and strap latch block
package ppsl_pkg;

	typedef enum logic [2:0] {
		PPSL_ST_HOLD = 3'b001,
		PPSL_ST_CFG  = 3'b010,
		PPSL_ST_RUN  = 3'b100
	} ppsl_state_e_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} ppsl_reg_req_t;

	typedef struct packed {
		ppsl_state_e_t st;
		logic [15:0]   cnt;
		logic [7:0]    mode;
		logic [7:0]    pcfg;
		logic          lp_latch;
		logic [1:0]    charge;
		logic [1:0]    nonrem_strap;
		logic [1:0]    pwr;
		logic [1:0]    pin_o;
		logic [1:0]    oe_n;
		logic [1:0]    rel_d1;
		logic [1:0]    rel_d2;
		logic [1:0]    oc;
		logic          self_pwr;
		logic [1:0]    nonrem;
		logic [7:0]    rdata;
		logic          rvalid;
	} ppsl_state_t;

endpackage : ppsl_pkg

// >>> hdl/ppsl_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module ppsl_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic [WIDTH-1:0] d_i,
	input  wire logic [WIDTH-1:0] rst_val_i,
	output logic      [WIDTH-1:0] q_o
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} ppsl_sync_t;

	ppsl_sync_t s_r;
	ppsl_sync_t s_nxt;

	always_comb begin
		s_nxt.s1 = d_i;
		s_nxt.s2 = s_r.s1;
	end

	// Flops reset to a fixed zero; rst_val_i only drives q_o while reset is held
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q_o = sys_rst_i ? rst_val_i : s_r.s2;
endmodule : ppsl_sync
`default_nettype wire

// >>> hdl/ppsl_top.sv
// Downstream port power control and strap latching, ports 3 and 4
`timescale 1ns/1ns
`default_nettype none
`include "ppsl_params.svh"
module ppsl_top #(
	parameter int CFG_CYCLES = `PPSL_CFG_CYCLES
) (
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   ext_rst_n_i,
	input  wire ppsl_pkg::ppsl_reg_req_t reg_req_i,
	input  wire logic                   otp_load_i,
	input  wire logic [7:0]             otp_mode_i,
	input  wire logic [1:0]             port_power_req_i,
	input  wire logic [1:0]             port_pin_i,
	output logic      [1:0]             port_pin_o,
	output logic      [1:0]             port_pin_oe_n_o,
	input  wire logic [1:0]             port_overcurrent_sense_n_i,
	input  wire logic                   self_power_detect_i,
	input  wire logic [1:0]             fixed_device_straps_i,
	output logic      [1:0]             port_power_enable_o,
	output logic      [1:0]             port_overcurrent_o,
	output logic      [1:0]             charge_support_o,
	output logic                        self_powered_o,
	output logic      [1:0]             non_removable_o,
	output logic                        hub_ready_o,
	output logic      [7:0]             reg_rdata_o,
	output logic                        reg_rvalid_o
);
	localparam ppsl_pkg::ppsl_state_t RST_STATE = '{
		st:   ppsl_pkg::PPSL_ST_HOLD,
		mode: `PPSL_MODE_RESET,
		pcfg: `PPSL_PCFG_RESET,
		oe_n: 2'h3,
		default: '0
	};
	localparam logic [15:0] CFG_LAST = 16'(CFG_CYCLES - 1);

	ppsl_pkg::ppsl_state_t s_r;
	ppsl_pkg::ppsl_state_t s_nxt;

	logic [7:0] sync_q;
	logic [1:0] pin_s;
	logic [1:0] ocs_n_s;
	logic       lp_s;
	logic [1:0] straps_s;
	logic       ext_s;
	logic       run;
	logic       dyn;

	ppsl_sync #(
		.WIDTH(8)
	) u_sync (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i      ({ext_rst_n_i, fixed_device_straps_i, self_power_detect_i,
		            port_overcurrent_sense_n_i, port_pin_i}),
		.rst_val_i(8'h00),
		.q_o      (sync_q)
	);

	assign pin_s    = sync_q[1:0];
	assign ocs_n_s  = sync_q[3:2];
	assign lp_s     = sync_q[4];
	assign straps_s = sync_q[6:5];
	assign ext_s    = sync_q[7];
	assign run      = (s_r.st == ppsl_pkg::PPSL_ST_RUN);
	assign dyn      = (s_r.mode == `PPSL_MODE_DYNAMIC);

	function automatic logic addr_hit(input logic [15:0] a,
	                                  input logic [15:0] t);
		addr_hit = (a == t);
	endfunction : addr_hit

	always_comb begin
		s_nxt = s_r;
		s_nxt.rvalid = 1'b0;
		unique case (s_r.st)
			ppsl_pkg::PPSL_ST_HOLD: begin
				s_nxt.cnt = 16'h0000;
				// Leaving hold marks power-on or external reset release
				if (ext_s) begin
					s_nxt.st = ppsl_pkg::PPSL_ST_CFG;
				end
			end
			ppsl_pkg::PPSL_ST_CFG: begin
				if (!ext_s) begin
					s_nxt.st = ppsl_pkg::PPSL_ST_HOLD;
				end else begin
					// Pins are released here, so the strap level is visible
					s_nxt.lp_latch     = lp_s;
					s_nxt.charge       = pin_s;
					s_nxt.nonrem_strap = straps_s;
					s_nxt.cnt          = s_r.cnt + 16'h0001;
					if (s_r.cnt == CFG_LAST) begin
						s_nxt.st = ppsl_pkg::PPSL_ST_RUN;
					end
				end
			end
			ppsl_pkg::PPSL_ST_RUN: begin
				if (!ext_s) begin
					s_nxt.st = ppsl_pkg::PPSL_ST_HOLD;
				end
			end
		endcase

		for (int i = 0; i < 2; i++) begin
			s_nxt.pwr[i] = run && port_power_req_i[i];
			s_nxt.rel_d1[i] = s_r.oe_n[i];
			s_nxt.rel_d2[i] = s_r.rel_d1[i];
			if (!run) begin
				s_nxt.pin_o[i] = 1'b0;
				s_nxt.oe_n[i]  = 1'b1;
			end else if (s_r.pcfg[`PPSL_PCFG_COMB_LSB + i]) begin
				// Open drain: pull low for off, release for on
				s_nxt.pin_o[i] = 1'b0;
				s_nxt.oe_n[i]  = s_nxt.pwr[i];
			end else begin
				s_nxt.pin_o[i] = s_nxt.pwr[i];
				s_nxt.oe_n[i]  = 1'b0;
			end
			// Sense only once the release has crossed the synchroniser
			if (s_r.pcfg[`PPSL_PCFG_COMB_LSB + i]) begin
				s_nxt.oc[i] = run && s_r.oe_n[i] && s_r.rel_d1[i] &&
				              s_r.rel_d2[i] && !pin_s[i];
			end else begin
				s_nxt.oc[i] = run && !ocs_n_s[i];
			end
		end

		// Latched value stays put unless dynamic tracking is selected
		s_nxt.self_pwr = dyn ? lp_s : s_r.lp_latch;
		if (s_r.pcfg[`PPSL_PCFG_LPD_BIT]) begin
			s_nxt.nonrem = s_r.pcfg[`PPSL_PCFG_NONREM_LSB +: 2];
		end else begin
			s_nxt.nonrem = s_r.nonrem_strap;
		end

		// Bus write beats an OTP load in the same cycle
		if (otp_load_i) begin
			s_nxt.mode = otp_mode_i;
		end
		if (reg_req_i.wr && addr_hit(reg_req_i.addr, `PPSL_MODE_ADDR)) begin
			s_nxt.mode = reg_req_i.wdata;
		end
		if (reg_req_i.wr && addr_hit(reg_req_i.addr, `PPSL_PCFG_ADDR)) begin
			s_nxt.pcfg = reg_req_i.wdata;
		end
		if (reg_req_i.rd) begin
			s_nxt.rvalid = 1'b1;
			if (addr_hit(reg_req_i.addr, `PPSL_MODE_ADDR)) begin
				s_nxt.rdata = s_r.mode;
			end else if (addr_hit(reg_req_i.addr, `PPSL_PCFG_ADDR)) begin
				s_nxt.rdata = s_r.pcfg;
			end else begin
				s_nxt.rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_r <= RST_STATE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign port_pin_o          = s_r.pin_o;
	assign port_pin_oe_n_o     = s_r.oe_n;
	assign port_power_enable_o = s_r.pwr;
	assign port_overcurrent_o  = s_r.oc;
	assign charge_support_o    = s_r.charge;
	assign self_powered_o      = s_r.self_pwr;
	assign non_removable_o     = s_r.nonrem;
	assign hub_ready_o         = run;
	assign reg_rdata_o         = s_r.rdata;
	assign reg_rvalid_o        = s_r.rvalid;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence seq_rst_release;
		$rose(ext_s);
	endsequence

	sequence seq_mode_write;
		reg_req_i.wr && reg_req_i.addr == `PPSL_MODE_ADDR;
	endsequence

	a_pwr_off_cfg:
	assert property (!$past(run) |-> port_power_enable_o == 2'h0 &&
	                 port_pin_oe_n_o == 2'h3)
	else $error("power enabled outside run");

	a_pwr_push_pull:
	assert property (run && $past(run) && !s_r.pcfg[`PPSL_PCFG_COMB_LSB] &&
	                 $past(!s_r.pcfg[`PPSL_PCFG_COMB_LSB])
	                 |-> port_pin_o[0] == $past(port_power_req_i[0]) &&
	                     !port_pin_oe_n_o[0])
	else $error("port power pin does not follow request");

	a_od_drive_low:
	assert property (run && $past(run) &&
	                 $past(s_r.pcfg[`PPSL_PCFG_COMB_LSB + 1])
	                 |-> !port_pin_o[1] &&
	                     port_pin_oe_n_o[1] == $past(port_power_req_i[1]))
	else $error("combined pin not open drain");

	a_charge_hold:
	assert property (run && $past(run) |-> $stable(charge_support_o))
	else $error("charge strap changed after configuration");

	a_local_latch:
	assert property (run && $past(run, 2) && $past(!dyn) && $past(!dyn, 2)
	                 |-> $stable(self_powered_o))
	else $error("latched local power changed");

	a_dyn_track:
	assert property ($past(dyn) |-> self_powered_o == $past(lp_s))
	else $error("dynamic local power not tracked");

	a_mode_write:
	assert property (seq_mode_write |=> s_r.mode == $past(reg_req_i.wdata))
	else $error("mode register write lost");

	a_nonrem_sel:
	assert property ($past(s_r.pcfg[`PPSL_PCFG_LPD_BIT])
	                 |-> non_removable_o == $past(s_r.pcfg[1:0]))
	else $error("non-removable not from register");

	a_cfg_on_release:
	assert property (seq_rst_release ##0 s_r.st == ppsl_pkg::PPSL_ST_HOLD
	                 |=> s_r.st == ppsl_pkg::PPSL_ST_CFG)
	else $error("no configuration after reset release");

	a_lp_sample:
	assert property (s_r.st == ppsl_pkg::PPSL_ST_CFG && ext_s
	                 |=> s_r.lp_latch == $past(lp_s))
	else $error("local power not sampled in configuration");
endmodule : ppsl_top
`default_nettype wire

// >>> verification/ppsl_pins_model.sv
// Pin wire model: power switches, strap resistors and pull-ups
`timescale 1ns/1ns
`default_nettype none
module ppsl_pins_model (
	input  wire logic [1:0] pin_o_i,
	input  wire logic [1:0] oe_n_i,
	input  wire logic [1:0] strap_i,
	input  wire logic [1:0] fault_i,
	output logic      [1:0] level_o
);
	// A switch fault sinks the released pin, beating the strap resistor
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			level_o[i] = oe_n_i[i] ? (strap_i[i] & ~fault_i[i])
				: pin_o_i[i];
		end
	end
endmodule : ppsl_pins_model
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the port power and strap latch block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic                    clk_i;
	logic                    sys_rst_i;
	logic                    ext_rst_n;
	ppsl_pkg::ppsl_reg_req_t req;
	logic                    otp_load;
	logic [7:0]              otp_mode;
	logic [7:0]              rdata;
	logic [1:0]              pwr_req, pin_o, oe_n, level, strap, fault;
	logic [1:0]              sense_n, fixed, pwr_en, oc, chg, nonrem;
	logic                    spd, self_p, ready, rvalid;
	int                      num_errors, checked, cycles;

	ppsl_top #(.CFG_CYCLES(4)) dut (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ext_rst_n_i(ext_rst_n),
		.reg_req_i(req), .otp_load_i(otp_load), .otp_mode_i(otp_mode),
		.port_power_req_i(pwr_req), .port_pin_i(level),
		.port_pin_o(pin_o), .port_pin_oe_n_o(oe_n),
		.port_overcurrent_sense_n_i(sense_n),
		.self_power_detect_i(spd), .fixed_device_straps_i(fixed),
		.port_power_enable_o(pwr_en), .port_overcurrent_o(oc),
		.charge_support_o(chg), .self_powered_o(self_p),
		.non_removable_o(nonrem), .hub_ready_o(ready),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid));
	ppsl_pins_model pins (.pin_o_i(pin_o), .oe_n_i(oe_n), .strap_i(strap),
		.fault_i(fault), .level_o(level));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	task automatic wrap_up();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask : tick

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i) req <= {1'b1, 1'b0, a, d};
		@(posedge clk_i) req <= '0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_i) req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clk_i) req <= '0;
		tick(1);
		chk({7'h00, rvalid}, 8'h01);
		chk(rdata, e);
	endtask : rd

	// Bounded wait: a configuration pass that never ends counts as a miss
	task automatic wait_ready();
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 200) begin
			tick(1);
			n++;
		end
		chk({7'h00, ready}, 8'h01);
	endtask : wait_ready

	task automatic t_cfg();
		tick(2);
		chk({6'h00, pwr_en}, 8'h00);
		wait_ready();
		tick(1);
		chk({6'h00, chg}, 8'h02);
		chk({7'h00, self_p}, 8'h01);
		chk({6'h00, nonrem}, 8'h01);
		chk({pin_o, oe_n, pwr_en}, 8'h33);
	endtask : t_cfg

	task automatic t_hold();
		@(posedge clk_i) spd <= 1'b0;
		strap <= 2'b01;
		pwr_req <= 2'b01;
		tick(6);
		chk({7'h00, self_p}, 8'h01);
		chk({6'h00, chg}, 8'h02);
		chk({6'h00, pwr_en}, 8'h01);
	endtask : t_hold

	task automatic t_dyn();
		rd(16'h4134, 8'hC1);
		rd(16'h4000, 8'h00);
		wr(16'h4134, 8'h41);
		rd(16'h4134, 8'h41);
		tick(5);
		chk({7'h00, self_p}, 8'h00);
		@(posedge clk_i) spd <= 1'b1;
		tick(5);
		chk({7'h00, self_p}, 8'h01);
		wr(16'h4134, 8'hC1);
		@(posedge clk_i) spd <= 1'b0;
		tick(5);
		chk({7'h00, self_p}, 8'h01);
		@(posedge clk_i) otp_mode <= 8'h41;
		otp_load <= 1'b1;
		@(posedge clk_i) otp_load <= 1'b0;
		rd(16'h4134, 8'h41);
		wr(16'h4134, 8'hC1);
	endtask : t_dyn

	task automatic t_comb();
		wr(16'h4135, 8'h04);
		tick(2);
		chk({oe_n[0], pwr_en[0]}, 8'h03);
		@(posedge clk_i) fault <= 2'b01;
		tick(8);
		chk({6'h00, oc}, 8'h01);
		@(posedge clk_i) fault <= 2'b00;
		pwr_req <= 2'b00;
		sense_n <= 2'b01;
		tick(5);
		chk({pin_o[0], oe_n[0], oc[1]}, 8'h01);
		@(posedge clk_i) sense_n <= 2'b11;
		// Port 4 combined and off, so its open-drain pin is pulled low
		wr(16'h4135, 8'h1A);
		tick(3);
		chk({6'h00, nonrem}, 8'h02);
		chk({6'h00, pin_o[1], oe_n[1]}, 8'h00);
		wr(16'h4135, 8'h00);
	endtask : t_comb

	task automatic t_ext();
		@(posedge clk_i) pwr_req <= 2'b11;
		ext_rst_n <= 1'b0;
		// Pin crosses two sync stages before the state leaves run
		tick(6);
		chk({6'h00, pwr_en}, 8'h00);
		@(posedge clk_i) ext_rst_n <= 1'b1;
		wait_ready();
		chk({6'h00, chg}, 8'h01);
		chk({7'h00, self_p}, 8'h00);
	endtask : t_ext

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			wrap_up();
		end
	end

	initial begin
		{num_errors, checked, cycles} = '0;
		{sys_rst_i, ext_rst_n, spd} = 3'b111;
		{req, otp_load, otp_mode, fault} = '0;
		{pwr_req, sense_n, strap, fixed} = 8'hF9;
		repeat (3) @(posedge clk_i);
		tick(1);
		chk({6'h00, pwr_en}, 8'h00);
		chk({6'h00, oe_n}, 8'h03);
		@(posedge clk_i) sys_rst_i <= 1'b0;
		t_cfg();
		t_hold();
		t_dyn();
		t_comb();
		t_ext();
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
